// file: logic/wake_frame_clock_recovery_cfg.sv
// configuration registers and bit-time recovery loop for selective wake
module wake_frame_clock_recovery_cfg #(
  parameter int CNT_W = 12,
  parameter int FRAC_W = 5
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_soft_rst,
  input wire logic i_restart,
  // serial pins
  input wire logic i_spi_cs_n,
  input wire logic i_spi_clk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // oscillator and bus
  input wire logic [7:0] i_calibration_low_byte,
  input wire logic i_osc_tick,
  input wire logic i_can_rx,
  // bit-time interface
  input wire logic [7:0] i_bit_time_value,
  output logic [7:0] o_bit_time_value,
  output logic o_recovery_enable
);
  logic [7:0] cal_low_r;
  logic recovery_enable_r;
  logic [1:0] filter_sel_r;
  logic [1:0] clock_sel_r;
  logic [7:0] upper_limit_r;
  logic [7:0] lower_limit_r;
  logic [7:0] rdata;
  logic [6:0] raddr;
  logic cmd_valid;
  wake_cdr_pkg::spi_cmd_t cmd;
  logic wr;
  logic [1:0] rx_meta_r;
  logic rx_s_r;
  logic [2:0] pre_r;
  logic rec_tick;
  logic [CNT_W-1:0] span_r;
  logic seen_edge_r;
  logic [7+FRAC_W:0] acc_r;
  logic fall_edge;
  logic [3:0] nbits;
  logic [CNT_W-1:0] per_bit;
  logic [2:0] shift;
  logic signed [8+FRAC_W:0] acc_sum;
  logic [7:0] acc_int;
  logic [7+FRAC_W:0] acc_nxt;

  wake_cdr_spi_slave u_spi (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_clk(i_spi_clk),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe),
    .i_rdata(rdata),
    .o_raddr(raddr),
    .o_cmd_valid(cmd_valid),
    .o_cmd(cmd)
  );

  assign wr = cmd_valid && cmd.write;

  // clamp a value into the programmed window
  function automatic logic [7:0] clamp(input logic [CNT_W-1:0] v,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    if (v > CNT_W'(hi)) begin
      clamp = hi;
    end else if (v < CNT_W'(lo)) begin
      clamp = lo;
    end else begin
      clamp = v[7:0];
    end
  endfunction

  // time constant as a shift, fixed or from the edge spacing
  function automatic logic [2:0] tc_shift(input logic [1:0] sel,
                                          input logic [3:0] n);
    unique case (sel)
      wake_cdr_pkg::FILT_TC8: tc_shift = wake_cdr_pkg::SHIFT_TC8;
      wake_cdr_pkg::FILT_TC16: tc_shift = wake_cdr_pkg::SHIFT_TC16;
      wake_cdr_pkg::FILT_TC32: tc_shift = wake_cdr_pkg::SHIFT_TC32;
      wake_cdr_pkg::FILT_ADAPT: begin
        if (n >= 4'(wake_cdr_pkg::ADAPT_FAST_MIN)) begin
          tc_shift = wake_cdr_pkg::SHIFT_TC8;
        end else if (n >= 4'(wake_cdr_pkg::ADAPT_SLOW_MIN)) begin
          tc_shift = wake_cdr_pkg::SHIFT_TC16;
        end else begin
          tc_shift = wake_cdr_pkg::SHIFT_TC32;
        end
      end
    endcase
  endfunction

  // calibration byte follows the oscillator, zero after any reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_low_r <= wake_cdr_pkg::RST_CAL_LOW;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        cal_low_r <= wake_cdr_pkg::RST_CAL_LOW;
      end else begin
        cal_low_r <= i_calibration_low_byte;
      end
    end
  end

  // control one: enable and filter; a restart leaves both untouched
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      recovery_enable_r <= wake_cdr_pkg::RST_RECOVERY_EN;
      filter_sel_r <= wake_cdr_pkg::RST_FILTER_SEL;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        recovery_enable_r <= wake_cdr_pkg::RST_RECOVERY_EN;
        filter_sel_r <= wake_cdr_pkg::RST_FILTER_SEL;
      end else if (i_restart) begin
        recovery_enable_r <= recovery_enable_r;
        filter_sel_r <= filter_sel_r;
      end else if (wr && cmd.addr == wake_cdr_pkg::ADDR_CTRL_ONE) begin
        recovery_enable_r <= cmd.data[wake_cdr_pkg::POS_RECOVERY_EN];
        filter_sel_r <= cmd.data[wake_cdr_pkg::POS_FILTER_LSB +: 2];
      end
    end
  end

  // control two and the clamp limits
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clock_sel_r <= wake_cdr_pkg::RST_CLOCK_SEL;
      upper_limit_r <= wake_cdr_pkg::RST_UPPER_LIMIT;
      lower_limit_r <= wake_cdr_pkg::RST_LOWER_LIMIT;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        clock_sel_r <= wake_cdr_pkg::RST_CLOCK_SEL;
        upper_limit_r <= wake_cdr_pkg::RST_UPPER_LIMIT;
        lower_limit_r <= wake_cdr_pkg::RST_LOWER_LIMIT;
      end else if (wr) begin
        if (cmd.addr == wake_cdr_pkg::ADDR_CTRL_TWO) begin
          clock_sel_r <= cmd.data[wake_cdr_pkg::POS_CLOCK_SEL_LSB +: 2];
        end
        if (cmd.addr == wake_cdr_pkg::ADDR_UPPER_LIMIT) begin
          upper_limit_r <= cmd.data;
        end
        if (cmd.addr == wake_cdr_pkg::ADDR_LOWER_LIMIT) begin
          lower_limit_r <= cmd.data;
        end
      end
    end
  end

  // read mux; reserved bits are never stored, so they read zero
  always_comb begin
    rdata = 8'h00;
    unique case (raddr)
      wake_cdr_pkg::ADDR_CAL_LOW: rdata = cal_low_r;
      wake_cdr_pkg::ADDR_CTRL_ONE: begin
        rdata[wake_cdr_pkg::POS_RECOVERY_EN] = recovery_enable_r;
        rdata[wake_cdr_pkg::POS_FILTER_LSB +: 2] = filter_sel_r;
      end
      wake_cdr_pkg::ADDR_CTRL_TWO: begin
        rdata[wake_cdr_pkg::POS_CLOCK_SEL_LSB +: 2] = clock_sel_r;
      end
      wake_cdr_pkg::ADDR_UPPER_LIMIT: rdata = upper_limit_r;
      wake_cdr_pkg::ADDR_LOWER_LIMIT: rdata = lower_limit_r;
      default: rdata = 8'h00;
    endcase
  end

  // bus receive pin synchroniser
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta_r <= 2'h3;
      rx_s_r <= 1'b1;
    end else if (i_clk_en) begin
      rx_meta_r <= {rx_meta_r[0], i_can_rx};
      rx_s_r <= rx_meta_r[1];
    end
  end
  assign fall_edge = rx_s_r && !rx_meta_r[1];

  // recovery clock: base tick divided by 1, 2, 4 or 8
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_r <= 3'h0;
    end else if (i_clk_en && i_osc_tick) begin
      pre_r <= pre_r + 3'h1;
    end
  end
  assign rec_tick = i_osc_tick &&
    ((pre_r & ((3'h1 << clock_sel_r) - 3'h1)) == 3'h0);

  // spacing in whole bits, rounded, and the per-bit count
  always_comb begin
    nbits = 4'h0;
    for (int k = 1; k <= wake_cdr_pkg::ADAPT_MAX_BITS; k++) begin
      if ({span_r, 1'b0} >= (CNT_W+1)'((2 * k - 1) * o_bit_time_value)) begin
        nbits = 4'(k);
      end
    end
    per_bit = (nbits == 4'h0) ? span_r : span_r / CNT_W'(nbits);
    shift = tc_shift(filter_sel_r, nbits);
    // filter step keeps its fraction unless a limit cuts in
    acc_sum = $signed({1'b0, acc_r}) +
      (($signed({1'b0, per_bit[7:0], FRAC_W'(0)}) -
        $signed({1'b0, acc_r})) >>> shift);
    acc_int = clamp(CNT_W'(acc_sum[8+FRAC_W:FRAC_W]), upper_limit_r,
                    lower_limit_r);
    acc_nxt = (acc_sum[8+FRAC_W:FRAC_W] == {1'b0, acc_int}) ?
      acc_sum[7+FRAC_W:0] : {acc_int, FRAC_W'(0)};
  end

  // edge-to-edge counter in recovery clock ticks, saturating
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      span_r <= '0;
      seen_edge_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!recovery_enable_r) begin
        span_r <= '0;
        seen_edge_r <= 1'b0;
      end else if (fall_edge) begin
        span_r <= '0;
        seen_edge_r <= 1'b1;
      end else if (rec_tick && span_r != '1) begin
        span_r <= span_r + CNT_W'(1);
      end
    end
  end

  // first-order filter on the estimate, held inside the limits
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r <= '0;
    end else if (i_clk_en) begin
      if (!recovery_enable_r) begin
        acc_r <= {i_bit_time_value, FRAC_W'(0)};
      end else if (fall_edge && seen_edge_r && nbits != 4'h0) begin
        acc_r <= acc_nxt;
      end
    end
  end

  assign o_bit_time_value = clamp(CNT_W'(acc_r[7+FRAC_W:FRAC_W]),
                                  upper_limit_r, lower_limit_r);
  assign o_recovery_enable = recovery_enable_r;
endmodule

// file: shared/wake_cdr_pkg.sv
// constants and carrier types of the wake clock recovery configuration slice
package wake_cdr_pkg;
  // register addresses, 7 bits
  localparam logic [6:0] ADDR_CAL_LOW = 7'h3B;
  localparam logic [6:0] ADDR_CTRL_ONE = 7'h3C;
  localparam logic [6:0] ADDR_CTRL_TWO = 7'h3D;
  localparam logic [6:0] ADDR_UPPER_LIMIT = 7'h3E;
  localparam logic [6:0] ADDR_LOWER_LIMIT = 7'h3F;
  // reset values
  localparam logic [7:0] RST_CAL_LOW = 8'h00;
  localparam logic [1:0] RST_FILTER_SEL = 2'h1;
  localparam logic RST_RECOVERY_EN = 1'b0;
  localparam logic [1:0] RST_CLOCK_SEL = 2'h0;
  localparam logic [7:0] RST_UPPER_LIMIT = 8'hA8;
  localparam logic [7:0] RST_LOWER_LIMIT = 8'h98;
  // field positions
  localparam int POS_RECOVERY_EN = 0;
  localparam int POS_FILTER_LSB = 2;
  localparam int POS_CLOCK_SEL_LSB = 0;
  // filter codes and time constants as shifts (8, 16, 32)
  localparam logic [1:0] FILT_TC8 = 2'h0;
  localparam logic [1:0] FILT_TC16 = 2'h1;
  localparam logic [1:0] FILT_TC32 = 2'h2;
  localparam logic [1:0] FILT_ADAPT = 2'h3;
  localparam logic [2:0] SHIFT_TC8 = 3'h3;
  localparam logic [2:0] SHIFT_TC16 = 3'h4;
  localparam logic [2:0] SHIFT_TC32 = 3'h5;
  // adaptive edge spacing bands in bits
  localparam int ADAPT_SLOW_MIN = 4;
  localparam int ADAPT_FAST_MIN = 9;
  localparam int ADAPT_MAX_BITS = 10;
  // recovery clock in MHz: base rate of the oscillator tick, halved per code
  localparam int RECOVERY_BASE_MHZ = 80;
  // serial command: address lsb first, then access mode, then data
  localparam int CMD_BITS = 16;
  localparam int CMD_MODE_BIT = 7;
  typedef struct packed {
    logic [6:0] addr;
    logic write;
    logic [7:0] data;
  } spi_cmd_t;
endpackage

// file: logic/wake_cdr_spi_slave.sv
// serial command port: 16-bit frames, lsb first, sampled on rising clock
module wake_cdr_spi_slave (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // serial pins
  input wire logic i_spi_cs_n,
  input wire logic i_spi_clk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // register side
  input wire logic [7:0] i_rdata,
  output logic [6:0] o_raddr,
  output logic o_cmd_valid,
  output wake_cdr_pkg::spi_cmd_t o_cmd
);
  logic [1:0] cs_meta_r, clk_meta_r, mosi_meta_r;
  logic [1:0] cs_s_r, clk_s_r;
  logic mosi_s_r;
  logic [15:0] shift_r;
  logic [4:0] count_r;
  logic [7:0] out_r;
  logic rise, fall, cs_act, cs_end;

  // two-flop synchronisers, then two stages for edges (one for serial data)
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_meta_r <= 2'h3;
      clk_meta_r <= 2'h0;
      mosi_meta_r <= 2'h0;
      cs_s_r <= 2'h3;
      clk_s_r <= 2'h0;
      mosi_s_r <= 1'b0;
    end else if (i_clk_en) begin
      cs_meta_r <= {cs_meta_r[0], i_spi_cs_n};
      clk_meta_r <= {clk_meta_r[0], i_spi_clk};
      mosi_meta_r <= {mosi_meta_r[0], i_spi_mosi};
      cs_s_r <= {cs_s_r[0], cs_meta_r[1]};
      clk_s_r <= {clk_s_r[0], clk_meta_r[1]};
      mosi_s_r <= mosi_meta_r[1];
    end
  end

  assign cs_act = !cs_s_r[0];
  assign cs_end = cs_s_r[0] && !cs_s_r[1];
  assign rise = cs_act && clk_s_r[0] && !clk_s_r[1];
  assign fall = cs_act && !clk_s_r[0] && clk_s_r[1];
  assign o_raddr = shift_r[14:8];

  // receive shift and bit count
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= 16'h0000;
      count_r <= 5'h00;
    end else if (i_clk_en) begin
      if (!cs_act) begin
        count_r <= 5'h00;
      end else if (rise) begin
        shift_r <= {mosi_s_r, shift_r[15:1]};
        if (count_r != 5'h1F) begin
          count_r <= count_r + 5'h01;
        end
      end
    end
  end

  // read data loaded after the address byte, shifted out lsb first
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_r <= 8'h00;
    end else if (i_clk_en) begin
      if (!cs_act) begin
        out_r <= 8'h00;
      end else if (fall && count_r == 5'h08) begin
        out_r <= i_rdata;
      end else if (fall && count_r > 5'h08) begin
        out_r <= {1'b0, out_r[7:1]};
      end
    end
  end

  // command issued when the frame closes with exactly sixteen bits
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
    end else if (i_clk_en) begin
      o_cmd_valid <= cs_end && count_r == 5'(wake_cdr_pkg::CMD_BITS);
      o_cmd.addr <= shift_r[6:0];
      o_cmd.write <= shift_r[wake_cdr_pkg::CMD_MODE_BIT];
      o_cmd.data <= shift_r[15:8];
    end
  end

  assign o_spi_miso = out_r[0];
  assign o_spi_miso_oe = cs_act;
endmodule

// file: testbench/wake_frame_clock_recovery_cfg_sva.sv
// port checker for the wake clock recovery configuration slice
module wake_frame_clock_recovery_cfg_sva #(
  parameter int CNT_W = 12,
  parameter int FRAC_W = 5
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_soft_rst,
  input wire logic i_restart,
  input wire logic i_spi_cs_n,
  input wire logic i_can_rx,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  input wire logic [7:0] o_bit_time_value,
  input wire logic o_recovery_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // quiet time since bus, port or mode activity
  logic rx_q;
  logic [3:0] quiet;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q <= 1'b1;
      quiet <= 4'h0;
    end else begin
      rx_q <= i_can_rx;
      if (i_can_rx != rx_q || !i_spi_cs_n || i_soft_rst ||
          !o_recovery_enable)
        quiet <= 4'h0;
      else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
    end
  end
  property p_oe_on;
    $fell(i_spi_cs_n) |-> ##[1:4] o_spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output enable late after select");
  property p_oe_off;
    i_spi_cs_n [*4] |-> !o_spi_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output enable while deselected");
  property p_miso_first;
    $rose(o_spi_miso_oe) |-> !o_spi_miso;
  endproperty
  a_miso_first: assert property (p_miso_first)
    else $error("serial out not low in first byte");
  property p_en_change;
    $changed(o_recovery_enable) |->
      $past(i_soft_rst) || (i_spi_cs_n && $past(i_spi_cs_n, 2));
  endproperty
  a_en_change: assert property (p_en_change)
    else $error("enable changed without a command");
  property p_soft_en;
    i_soft_rst && i_clk_en |=> !o_recovery_enable;
  endproperty
  a_soft_en: assert property (p_soft_en)
    else $error("soft reset left recovery enabled");
  property p_restart_keep;
    i_restart && !i_soft_rst && i_spi_cs_n && $past(i_spi_cs_n, 6) |=>
      $stable(o_recovery_enable);
  endproperty
  a_restart_keep: assert property (p_restart_keep)
    else $error("restart changed the enable");
  property p_soft_clamp;
    (i_soft_rst && i_clk_en) [*2] |-> ##1
      (o_bit_time_value >= 8'h98 && o_bit_time_value <= 8'hA8);
  endproperty
  a_soft_clamp: assert property (p_soft_clamp)
    else $error("estimate outside default limits");
  property p_quiet_hold;
    quiet >= 4'h8 |-> $stable(o_bit_time_value);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold)
    else $error("estimate moved without a bus edge");
endmodule
bind wake_frame_clock_recovery_cfg wake_frame_clock_recovery_cfg_sva #(
  .CNT_W(CNT_W),
  .FRAC_W(FRAC_W)
) chk_u (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_clk_en(i_clk_en),
  .i_soft_rst(i_soft_rst),
  .i_restart(i_restart),
  .i_spi_cs_n(i_spi_cs_n),
  .i_can_rx(i_can_rx),
  .o_spi_miso(o_spi_miso),
  .o_spi_miso_oe(o_spi_miso_oe),
  .o_bit_time_value(o_bit_time_value),
  .o_recovery_enable(o_recovery_enable)
);

// file: testbench/can_bus_model.sv
// bus model: alternating bits, recessive high when idle
module can_bus_model (
  input wire logic i_ref_clk,
  input wire logic i_active,
  input wire logic [15:0] i_bit_cycles,
  output logic o_can_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  initial begin
    o_can_rx = 1'b1;
    cnt = 16'h0000;
  end
  always @(posedge i_ref_clk) begin
    #1;
    if (!i_active && o_can_rx) begin
      cnt = 16'h0000;
    end else if (cnt >= i_bit_cycles - 16'h0001) begin
      cnt = 16'h0000;
      o_can_rx = !o_can_rx;
    end else begin
      cnt = cnt + 16'h0001;
    end
  end
endmodule

// file: testbench/wake_frame_clock_recovery_cfg_tb.sv
// register and recovery tests for the wake clock recovery slice
module wake_frame_clock_recovery_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_rst_n, i_clk_en, i_soft_rst, i_restart, i_osc_tick;
  logic i_spi_cs_n, i_spi_clk, i_spi_mosi, o_spi_miso, o_spi_miso_oe;
  logic can_rx, bus_active, o_recovery_enable;
  logic [7:0] i_calibration_low_byte, i_bit_time_value, o_bit_time_value;
  logic [15:0] bit_cycles;
  int miscompares, checks;
  logic [7:0] rst_exp [5] = '{8'h00, 8'h04, 8'h00, 8'hA8, 8'h98};
  logic [7:0] rec_c1 [7] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h05, 8'h05, 8'h05};
  logic [7:0] rec_c2 [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] rec_x [7] = '{8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'h98, 8'hA0};
  wake_frame_clock_recovery_cfg dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_soft_rst(i_soft_rst), .i_restart(i_restart),
    .i_spi_cs_n(i_spi_cs_n), .i_spi_clk(i_spi_clk),
    .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe),
    .i_calibration_low_byte(i_calibration_low_byte),
    .i_osc_tick(i_osc_tick), .i_can_rx(can_rx),
    .i_bit_time_value(i_bit_time_value),
    .o_bit_time_value(o_bit_time_value),
    .o_recovery_enable(o_recovery_enable));
  can_bus_model bus_u (.i_ref_clk(i_ref_clk), .i_active(bus_active),
    .i_bit_cycles(bit_cycles), .o_can_rx(can_rx));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one 16-bit frame, lsb first, data byte captured from serial out
  task automatic spi(input logic [6:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    wake_cdr_pkg::spi_cmd_t c;
    logic [15:0] f;
    c = '{addr: a, write: w, data: d};
    f = {c.data, c.write, c.addr};
    q = 8'h00;
    i_spi_cs_n = 1'b0;
    for (int i = 0; i < wake_cdr_pkg::CMD_BITS; i++) begin
      i_spi_mosi = f[i];
      step(4);
      if (i >= 8)
        q[i-8] = o_spi_miso;
      i_spi_clk = 1'b1;
      step(4);
      i_spi_clk = 1'b0;
    end
    step(4);
    i_spi_cs_n = 1'b1;
    step(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    spi(a, 1'b0, 8'h00, q);
    check(q, exp);
  endtask
  task automatic rd_defaults;
    for (int i = 0; i < 5; i++)
      rd(wake_cdr_pkg::ADDR_CAL_LOW + 7'(i), rst_exp[i]);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    step(90000);
    miscompares++;
    give_verdict();
  end
  initial begin
    i_rst_n = 1'b0;
    i_clk_en = 1'b1;
    i_soft_rst = 1'b0;
    i_restart = 1'b0;
    i_osc_tick = 1'b1;
    i_spi_cs_n = 1'b1;
    i_spi_clk = 1'b0;
    i_spi_mosi = 1'b0;
    i_calibration_low_byte = 8'h00;
    i_bit_time_value = 8'hA0;
    bit_cycles = 16'd190;
    bus_active = 1'b0;
    step(6);
    i_rst_n = 1'b1;
    step(4);
    rd_defaults();
    rd(7'h40, 8'h00);
    i_calibration_low_byte = 8'h5A;
    wr(wake_cdr_pkg::ADDR_CAL_LOW, 8'hFF);
    rd(wake_cdr_pkg::ADDR_CAL_LOW, 8'h5A);
    wr(wake_cdr_pkg::ADDR_CTRL_ONE, 8'hFF);
    check(8'(o_recovery_enable), 8'h01);
    rd(wake_cdr_pkg::ADDR_CTRL_ONE, 8'h0D);
    wr(wake_cdr_pkg::ADDR_CTRL_TWO, 8'hFF);
    rd(wake_cdr_pkg::ADDR_CTRL_TWO, 8'h03);
    i_restart = 1'b1;
    step(1);
    i_restart = 1'b0;
    rd(wake_cdr_pkg::ADDR_CTRL_ONE, 8'h0D);
    rd(wake_cdr_pkg::ADDR_CTRL_TWO, 8'h03);
    wr(wake_cdr_pkg::ADDR_UPPER_LIMIT, 8'hB0);
    rd(wake_cdr_pkg::ADDR_UPPER_LIMIT, 8'hB0);
    // clock enable low freezes everything, soft reset included
    i_clk_en = 1'b0;
    i_soft_rst = 1'b1;
    step(3);
    i_soft_rst = 1'b0;
    i_clk_en = 1'b1;
    rd(wake_cdr_pkg::ADDR_UPPER_LIMIT, 8'hB0);
    check(8'(o_recovery_enable), 8'h01);
    i_soft_rst = 1'b1;
    step(3);
    i_soft_rst = 1'b0;
    i_calibration_low_byte = 8'h00;
    step(2);
    rd_defaults();
    // clamping while disabled
    i_bit_time_value = 8'hFF;
    step(4);
    check(o_bit_time_value, 8'hA8);
    i_bit_time_value = 8'h10;
    step(4);
    check(o_bit_time_value, 8'h98);
    wr(wake_cdr_pkg::ADDR_LOWER_LIMIT, 8'h40);
    check(o_bit_time_value, 8'h40);
    wr(wake_cdr_pkg::ADDR_LOWER_LIMIT, 8'h98);
    i_bit_time_value = 8'hA0;
    // recovery runs at each filter code and clock selection
    for (int r = 0; r < 7; r++) begin
      wr(wake_cdr_pkg::ADDR_CTRL_ONE, rec_c1[r] & 8'hFE);
      check(o_bit_time_value, 8'hA0);
      wr(wake_cdr_pkg::ADDR_CTRL_TWO, rec_c2[r]);
      wr(wake_cdr_pkg::ADDR_CTRL_ONE, rec_c1[r]);
      bus_active = 1'b1;
      step(20 * 2 * 190);
      bus_active = 1'b0;
      step(400);
      check(o_bit_time_value, rec_x[r]);
    end
    give_verdict();
  end
endmodule
